/* src/system_clock_source_select.sv */
// Top of the system clock source select block with Wishbone registers
//
// Design decisions made here: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
module system_clock_source_select
    import sysclk_sel_pkg::*;
(
    // Clock and reset
    input  wire logic              ref_clk_i,
    input  wire logic              rst_i,
    // Wishbone classic slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADR_W-1:0]  wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // Configuration word one
    input  wire logic [2:0]        cfg_osc_mode_i,
    input  wire logic              cfg_two_speed_i,
    // Restart events
    input  wire logic              por_event_i,
    input  wire logic              wake_event_i,
    input  wire logic              powerup_delay_en_i,
    input  wire logic              powerup_delay_done_i,
    // Oscillator sources
    input  wire logic              osc_in_pin_i,
    input  wire logic              fast_osc_tick_i,
    input  wire logic              slow_osc_tick_i,
    input  wire logic              fast_osc_ready_i,
    input  wire logic              slow_osc_ready_i,
    // GPIO use of the output pin
    input  wire logic              gpio_out_i,
    input  wire logic              gpio_oe_n_i,
    // System clock and execution
    output logic                   sysclk_tick_o,
    output logic                   cpu_run_o,
    // Oscillator control
    output logic [1:0]             amp_gain_o,
    output logic                   fast_osc_en_o,
    output logic                   slow_osc_en_o,
    output logic [TRIM_W-1:0]      fast_osc_trim_o,
    // Pins
    output logic                   osc_out_pin_o,
    output logic                   osc_out_pin_oe_n_o,
    output logic                   osc_in_gpio_o,
    output logic                   osc_out_gpio_o
);
    typedef struct packed {
        boot_state_t        boot;
        logic               cfg_loaded;
        logic [2:0]         mode;
        logic               two_speed;
        logic [FREQ_W-1:0]  freq;
        logic               origin;
        logic [TRIM_W-1:0]  trim;
        logic               ack;
        logic [31:0]        dat;
        logic               in_prev;
        logic [POST_W-1:0]  post_cnt;
        logic               tick;
        logic               run;
        logic               offchip;
        logic               fast_stable;
        logic               slow_stable;
        logic               fast_en;
        logic               slow_en;
        logic [1:0]         gain;
        logic               out_pin;
        logic               out_oe_n;
        logic               in_gpio;
        logic               out_gpio;
        logic               warm_start;
    } top_state_t;

    top_state_t cur;
    top_state_t next_cur;
    logic       quarter;
    logic       osc_edge;

    warm_if warm ();

    // Crystal modes need the warm-up count
    function automatic logic is_crystal(input logic [2:0] m);
        return (m == MODE_LOW_GAIN) || (m == MODE_MID_GAIN) || (m == MODE_HIGH_GAIN);
    endfunction

    // Modes that run from the on-chip oscillators
    function automatic logic is_onchip(input logic [2:0] m);
        return (m == MODE_ONCHIP_Q) || (m == MODE_ONCHIP_IO);
    endfunction

    // Postscaler mask: 111 passes every fast tick, 001 one in 64
    function automatic logic [POST_W-1:0] post_mask(input logic [FREQ_W-1:0] f);
        return POST_W'((8'h01 << (FREQ_MAX - f)) - 8'h01);
    endfunction

    assign osc_edge       = osc_in_pin_i & ~cur.in_prev;
    assign warm.edge_seen = osc_edge;
    assign warm.start     = cur.warm_start;

    // Next state of the whole block
    always_comb begin
        logic onchip_sel;
        logic src_tick;
        logic wb_req;
        onchip_sel = 1'b0;
        src_tick   = 1'b0;
        wb_req     = 1'b0;
        next_cur   = cur;
        next_cur.warm_start = 1'b0;
        next_cur.in_prev    = osc_in_pin_i;

        // Catch configuration after reset release and on power-on
        if (!cur.cfg_loaded || por_event_i) begin
            next_cur.mode       = cfg_osc_mode_i;
            next_cur.two_speed  = cfg_two_speed_i;
            next_cur.cfg_loaded = 1'b1;
        end

        // Start-up sequence
        case (cur.boot)
            ST_PWRUP: begin
                if (cur.cfg_loaded && (!powerup_delay_en_i || powerup_delay_done_i)) begin
                    if (is_crystal(cur.mode)) begin
                        next_cur.boot       = ST_WARM;
                        next_cur.warm_start = 1'b1;
                    end else begin
                        next_cur.boot = ST_RUN;
                    end
                end
            end
            ST_WARM: begin
                if (!cur.warm_start && warm.done) begin
                    next_cur.boot = ST_RUN;
                end
            end
            ST_RUN: begin
                if (wake_event_i && is_crystal(cur.mode)) begin
                    next_cur.boot       = ST_WARM;
                    next_cur.warm_start = 1'b1;
                end
            end
            default: begin
                next_cur.boot = ST_PWRUP;
            end
        endcase
        if (por_event_i) begin
            next_cur.boot = ST_PWRUP;
        end
        next_cur.run = (next_cur.boot == ST_RUN);

        // Clock origin: on-chip when selected or configured
        onchip_sel = cur.origin || is_onchip(cur.mode);
        if (fast_osc_tick_i) begin
            next_cur.post_cnt = cur.post_cnt + 1'b1;
        end
        if (onchip_sel) begin
            if (cur.freq == FREQ_SLOW) begin
                src_tick = slow_osc_tick_i;
            end else begin
                src_tick = fast_osc_tick_i &&
                           ((cur.post_cnt & post_mask(cur.freq)) == post_mask(cur.freq));
            end
        end else begin
            src_tick = osc_edge;
        end
        // Ticks alone move the system; no tick, nothing changes
        next_cur.tick = src_tick;
        next_cur.offchip = !onchip_sel && (cur.boot == ST_RUN);

        // Oscillator enables and stable flags
        next_cur.fast_en = (cur.freq != FREQ_SLOW) &&
                           (cur.origin || cur.two_speed || is_onchip(cur.mode));
        next_cur.slow_en = ((cur.freq == FREQ_SLOW) &&
                            (cur.origin || cur.two_speed || is_onchip(cur.mode))) ||
                           powerup_delay_en_i;
        next_cur.fast_stable = fast_osc_ready_i && cur.fast_en;
        next_cur.slow_stable = slow_osc_ready_i && cur.slow_en;

        // Amplifier gain
        case (cur.mode)
            MODE_LOW_GAIN:  next_cur.gain = GAIN_LOW;
            MODE_MID_GAIN:  next_cur.gain = GAIN_MID;
            MODE_HIGH_GAIN: next_cur.gain = GAIN_HIGH;
            default:        next_cur.gain = GAIN_OFF;
        endcase

        // Pin use per mode
        next_cur.in_gpio  = 1'b0;
        next_cur.out_gpio = 1'b0;
        next_cur.out_pin  = 1'b0;
        next_cur.out_oe_n = 1'b1;
        case (cur.mode)
            MODE_DRIVEN, MODE_RC_IO: begin
                next_cur.out_gpio = 1'b1;
            end
            MODE_RC: begin
                next_cur.out_pin  = quarter;
                next_cur.out_oe_n = 1'b0;
            end
            MODE_ONCHIP_Q: begin
                next_cur.in_gpio  = 1'b1;
                next_cur.out_pin  = quarter;
                next_cur.out_oe_n = 1'b0;
            end
            MODE_ONCHIP_IO: begin
                next_cur.in_gpio  = 1'b1;
                next_cur.out_gpio = 1'b1;
            end
            default: begin
                next_cur.out_oe_n = 1'b1;
            end
        endcase
        if (next_cur.out_gpio) begin
            next_cur.out_pin  = gpio_out_i;
            next_cur.out_oe_n = gpio_oe_n_i;
        end

        // Wishbone slave: one-cycle answer, ack dropped next cycle
        wb_req       = wb_cyc_i && wb_stb_i && !cur.ack;
        next_cur.ack = wb_req;
        next_cur.dat = 32'h0000_0000;
        if (wb_req) begin
            case (wb_adr_i)
                ADDR_CTRL: begin
                    next_cur.dat[CTRL_FREQ_LSB +: FREQ_W] = cur.freq;
                    next_cur.dat[CTRL_OFFCHIP_BIT]        = cur.offchip;
                    next_cur.dat[CTRL_FAST_BIT]           = cur.fast_stable;
                    next_cur.dat[CTRL_SLOW_BIT]           = cur.slow_stable;
                    next_cur.dat[CTRL_ORIGIN_BIT]         = cur.origin;
                    if (wb_we_i && wb_sel_i[0]) begin
                        next_cur.freq   = wb_dat_i[CTRL_FREQ_LSB +: FREQ_W];
                        next_cur.origin = wb_dat_i[CTRL_ORIGIN_BIT];
                    end
                end
                ADDR_TRIM: begin
                    next_cur.dat[TRIM_W-1:0] = cur.trim;
                    if (wb_we_i && wb_sel_i[0]) begin
                        next_cur.trim = wb_dat_i[TRIM_W-1:0];
                    end
                end
                ADDR_CFG: begin
                    next_cur.dat[2:0]              = cur.mode;
                    next_cur.dat[CFG_TWO_SPEED_BIT] = cur.two_speed;
                end
                default: begin
                    next_cur.dat = 32'h0000_0000;
                end
            endcase
        end else begin
            next_cur.dat = cur.dat;
        end
    end

    // State register
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cur        <= '0;
            cur.boot   <= ST_PWRUP;
            cur.freq   <= FREQ_RESET;
            cur.origin <= ORIGIN_RESET;
            cur.trim   <= TRIM_RESET;
            cur.out_oe_n <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    // Warm-up counter
    crystal_warmup_counter #(
        .COUNT (WARMUP_COUNT)
    ) u_warm (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .warm      (warm.cnt)
    );

    // Quarter-rate clock output, held low while stalled
    quarter_clock_divider #(
        .DIV (QUARTER_DIV)
    ) u_quarter (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .clear_i   (~cur.run),
        .tick_i    (cur.tick),
        .quarter_o (quarter)
    );

    // Outputs straight from the state register
    assign wb_dat_o           = cur.dat;
    assign wb_ack_o           = cur.ack;
    assign sysclk_tick_o      = cur.tick;
    assign cpu_run_o          = cur.run;
    assign amp_gain_o         = cur.gain;
    assign fast_osc_en_o      = cur.fast_en;
    assign slow_osc_en_o      = cur.slow_en;
    assign fast_osc_trim_o    = cur.trim;
    assign osc_out_pin_o      = cur.out_pin;
    assign osc_out_pin_oe_n_o = cur.out_oe_n;
    assign osc_in_gpio_o      = cur.in_gpio;
    assign osc_out_gpio_o     = cur.out_gpio;

    // Edge tally during warm-up, for checking only
    logic [WARM_W-1:0] edge_tally;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || cur.warm_start) begin
            edge_tally <= '0;
        end else if (cur.boot == ST_WARM && osc_edge && !warm.done) begin
            edge_tally <= edge_tally + 1'b1;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    a_warm_count_full: assert property (
        ($rose(cpu_run_o) && $past(cur.boot == ST_WARM)) |-> (edge_tally == WARM_W'(WARMUP_COUNT)))
        else $error("warm-up ended before 1024 edges");
    a_warm_stalls_cpu: assert property (
        (cur.warm_start && cur.boot == ST_WARM) |-> !cpu_run_o [*2])
        else $error("execution ran during warm-up");
    a_driven_no_wait: assert property (
        (cur.boot == ST_PWRUP && cur.cfg_loaded && cur.mode == MODE_DRIVEN && !por_event_i &&
         (!powerup_delay_en_i || powerup_delay_done_i)) |=> cpu_run_o)
        else $error("driven clock mode did not start at once");
    a_driven_pins: assert property (
        (cur.mode == MODE_DRIVEN) |=> (osc_out_gpio_o && !osc_in_gpio_o))
        else $error("driven clock mode pin use wrong");
    a_gain_select: assert property (
        (cur.mode == MODE_LOW_GAIN) |=> (amp_gain_o == GAIN_LOW))
        else $error("low gain crystal mode gain wrong");
    a_rc_quarter_out: assert property (
        (cur.mode == MODE_RC) |=> (!osc_out_pin_oe_n_o && !osc_out_gpio_o))
        else $error("rc mode does not drive quarter clock");
    a_rc_free_pin: assert property (
        (cur.mode == MODE_RC_IO) |=> (osc_out_gpio_o && !osc_in_gpio_o))
        else $error("rc pins-free mode pin use wrong");
    a_onchip_pins: assert property (
        (cur.mode == MODE_ONCHIP_IO) |=> (osc_out_gpio_o && osc_in_gpio_o))
        else $error("on-chip all-pins mode pin use wrong");
    a_fast_enable: assert property (
        (cur.freq != FREQ_SLOW && cur.origin) |=> fast_osc_en_o)
        else $error("fast oscillator not enabled");
    a_freq_reset: assert property (
        $fell(rst_i) |-> (cur.freq == FREQ_RESET))
        else $error("frequency select not 110 after reset");
    a_offchip_flag: assert property (
        cur.origin |=> !cur.offchip)
        else $error("off-chip flag set on on-chip clock");
    a_bus_ack: assert property (
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer not one cycle");
endmodule // system_clock_source_select

/* src/sysclk_sel_pkg.sv */
// Constants and types for the system clock source select block
// Function
// - Crystal modes count 1024 osc-in edges after power-on or wake.
// - While warm-up counts, execution is stalled and the program counter held.
// - Driven-clock mode skips warm-up; execution starts at once.
// - Driven-clock mode clocks from osc-in and frees osc-out as GPIO.
// - Logic is static; a stopped clock freezes state, restart resumes.
// - Low, mid, high gain crystal modes select amplifier gain low, mid, high.
// - RC mode drives osc-out with the RC clock divided by four.
// - RC pins-free mode keeps RC on osc-in, osc-out becomes GPIO.
// - On-chip quarter-out mode frees osc-in, osc-out carries clock divided by four.
// - On-chip all-pins mode frees both osc-in and osc-out as GPIO.
// - On-chip modes come from the mode field of config word one.
// - Software origin select bit picks external or on-chip system clock.
// - Fast 8 MHz oscillator feeds a postscaler giving seven selectable rates.
// - Slow 31 kHz oscillator is selectable through the frequency select field.
// - Fast oscillator enabled when select nonzero and origin or two-speed set.
// - A readable flag reports whether the fast oscillator is stable.
// - Any reset loads frequency select with 110, meaning 4 MHz; here only rst_i loads it, por_event_i leaves it unchanged.
// - Origin bit one routes on-chip clock; zero uses the configured mode.
// - Off-chip running flag is one on external clock, zero on on-chip.
package sysclk_sel_pkg;
    // Crystal warm-up
    localparam int WARMUP_COUNT = 1024;
    localparam int WARM_W       = 11;
    localparam int QUARTER_DIV  = 4;
    // Oscillator mode codes of config word one
    localparam logic [2:0] MODE_LOW_GAIN  = 3'h0;
    localparam logic [2:0] MODE_MID_GAIN  = 3'h1;
    localparam logic [2:0] MODE_HIGH_GAIN = 3'h2;
    localparam logic [2:0] MODE_DRIVEN    = 3'h3;
    localparam logic [2:0] MODE_ONCHIP_Q  = 3'h4;
    localparam logic [2:0] MODE_ONCHIP_IO = 3'h5;
    localparam logic [2:0] MODE_RC        = 3'h6;
    localparam logic [2:0] MODE_RC_IO     = 3'h7;
    // Amplifier gain codes
    localparam logic [1:0] GAIN_OFF  = 2'h0;
    localparam logic [1:0] GAIN_LOW  = 2'h1;
    localparam logic [1:0] GAIN_MID  = 2'h2;
    localparam logic [1:0] GAIN_HIGH = 2'h3;
    // Register map (byte addresses)
    localparam int         ADR_W     = 4;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_TRIM = 4'h4;
    localparam logic [3:0] ADDR_CFG  = 4'h8;
    // Control register fields
    localparam int CTRL_FREQ_LSB    = 4;
    localparam int CTRL_OFFCHIP_BIT = 3;
    localparam int CTRL_FAST_BIT    = 2;
    localparam int CTRL_SLOW_BIT    = 1;
    localparam int CTRL_ORIGIN_BIT  = 0;
    localparam int CFG_TWO_SPEED_BIT = 3;
    localparam int FREQ_W = 3;
    localparam int TRIM_W = 5;
    localparam int POST_W = 7;
    localparam logic [2:0] FREQ_RESET  = 3'h6;
    localparam logic [2:0] FREQ_SLOW   = 3'h0;
    localparam logic [2:0] FREQ_MAX    = 3'h7;
    localparam logic       ORIGIN_RESET = 1'b0;
    localparam logic [4:0] TRIM_RESET  = 5'h00;
    // Start-up sequence states
    typedef enum logic [2:0] {
        ST_PWRUP = 3'b001,
        ST_WARM  = 3'b010,
        ST_RUN   = 3'b100
    } boot_state_t;
endpackage

/* src/warm_if.sv */
// Interface between start-up control and crystal warm-up counter
`timescale 1ns/1ps
interface warm_if;
    logic start;
    logic edge_seen;
    logic done;
    modport ctl (output start, output edge_seen, input done);
    modport cnt (input start, input edge_seen, output done);
endinterface

/* src/crystal_warmup_counter.sv */
// Counts oscillator input edges until the crystal is warmed up
`timescale 1ns/1ps
module crystal_warmup_counter
    import sysclk_sel_pkg::*;
#(
    parameter int COUNT = WARMUP_COUNT
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Control side
    warm_if.cnt      warm
);
    typedef struct packed {
        logic [WARM_W-1:0] count;
        logic              done;
    } warm_state_t;

    warm_state_t cur;
    warm_state_t next_cur;

    // Restart on start, count edges up to the full count
    always_comb begin
        next_cur = cur;
        if (warm.start) begin
            next_cur.count = '0;
            next_cur.done  = 1'b0;
        end else if (!cur.done && warm.edge_seen) begin
            next_cur.count = cur.count + 1'b1;
            if (cur.count == WARM_W'(COUNT - 1)) begin
                next_cur.done = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign warm.done = cur.done;
endmodule // crystal_warmup_counter

/* src/quarter_clock_divider.sv */
// Divides the system clock tick stream into a quarter-rate square wave
`timescale 1ns/1ps
module quarter_clock_divider
    import sysclk_sel_pkg::*;
#(
    parameter int DIV = QUARTER_DIV
) (
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    // Tick input
    input  wire logic clear_i,
    input  wire logic tick_i,
    // Divided level
    output logic      quarter_o
);
    localparam int HALF = DIV / 2;
    localparam int CW   = (HALF > 1) ? $clog2(HALF) : 1;

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          level;
    } div_state_t;

    div_state_t cur;
    div_state_t next_cur;

    // Toggle level every half period of ticks
    always_comb begin
        next_cur = cur;
        if (clear_i) begin
            next_cur = '0;
        end else if (tick_i) begin
            if (cur.cnt == CW'(HALF - 1)) begin
                next_cur.cnt   = '0;
                next_cur.level = ~cur.level;
            end else begin
                next_cur.cnt = cur.cnt + 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign quarter_o = cur.level;
endmodule // quarter_clock_divider

/* tb/osc_source_model.sv */
// Behavioural crystal, driven clock and on-chip oscillator sources
`timescale 1ns/1ps
module osc_source_model #(
    parameter int HALF   = 4,
    parameter int FAST_P = 6,
    parameter int SLOW_P = 20
) (
    // Clock and controls
    input  wire logic ref_clk_i,
    input  wire logic run_i,
    input  wire logic fast_en_i,
    input  wire logic slow_en_i,
    // Source outputs
    output logic      osc_o,
    output logic      fast_tick_o,
    output logic      slow_tick_o,
    output logic      fast_rdy_o,
    output logic      slow_rdy_o
);
    int h = 0;
    int f = 0;
    int s = 0;
    initial {osc_o, fast_tick_o, slow_tick_o, fast_rdy_o, slow_rdy_o} = 5'h00;
    // Pin toggles only while the source runs; a stopped source holds its level
    always @(posedge ref_clk_i) begin
        if (run_i) begin
            h <= (h == HALF - 1) ? 0 : h + 1;
            osc_o <= (h == HALF - 1) ? ~osc_o : osc_o;
        end
        f <= (f == FAST_P - 1) ? 0 : f + 1;
        s <= (s == SLOW_P - 1) ? 0 : s + 1;
        // Disabled oscillators give neither pulses nor ready
        fast_tick_o <= fast_en_i && f == FAST_P - 1;
        slow_tick_o <= slow_en_i && s == SLOW_P - 1;
        fast_rdy_o <= fast_en_i;
        slow_rdy_o <= slow_en_i;
    end
endmodule // osc_source_model

/* tb/testbench.sv */
// Self-checking bench for the system clock source select block
`timescale 1ns/1ps
module testbench;
    import sysclk_sel_pkg::*;
    logic ref_clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0, rdat;
    logic [2:0] mode = MODE_DRIVEN;
    logic two = 1'b0, por = 1'b0, wake = 1'b0, osc_run = 1'b1;
    logic ack, osc, ftick, stick, frdy, srdy, tick, run, fen, sen, qout, qoe_n, in_io, out_io;
    logic [1:0] gain;
    logic [4:0] trim;
    logic [1:0] io_exp [8] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h1};
    int errors = 0;
    int comparisons = 0;
    // Clock
    always #10 ref_clk_i = ~ref_clk_i;
    system_clock_source_select system_clock_source_select_inst (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .cfg_osc_mode_i(mode), .cfg_two_speed_i(two), .por_event_i(por),
        .wake_event_i(wake), .powerup_delay_en_i(1'b0), .powerup_delay_done_i(1'b1),
        .osc_in_pin_i(osc), .fast_osc_tick_i(ftick), .slow_osc_tick_i(stick),
        .fast_osc_ready_i(frdy), .slow_osc_ready_i(srdy), .gpio_out_i(1'b0),
        .gpio_oe_n_i(1'b1), .sysclk_tick_o(tick), .cpu_run_o(run), .amp_gain_o(gain),
        .fast_osc_en_o(fen), .slow_osc_en_o(sen), .fast_osc_trim_o(trim),
        .osc_out_pin_o(qout), .osc_out_pin_oe_n_o(qoe_n), .osc_in_gpio_o(in_io),
        .osc_out_gpio_o(out_io));
    osc_source_model osc_source_model_inst (
        .ref_clk_i(ref_clk_i), .run_i(osc_run), .fast_en_i(fen), .slow_en_i(sen),
        .osc_o(osc), .fast_tick_o(ftick), .slow_tick_o(stick), .fast_rdy_o(frdy),
        .slow_rdy_o(srdy));
    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    // One classic Wishbone cycle held until ack
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, d};
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (ack !== 1'b1);
        q = rdat;
        {cyc, stb} <= 2'b00;
        @(posedge ref_clk_i);
        chk(32'(n < 20), 32'h1, "bus answer");
    endtask
    // Restart with a given configuration
    task automatic boot(input logic [2:0] m, input logic t);
        {mode, two, por} <= {m, t, 1'b1};
        @(posedge ref_clk_i);
        por <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    // Wait for execution, counting oscillator input rising edges
    task automatic wait_run(input int lim, inout int e, output int c);
        logic prev;
        c = 0;
        prev = osc;
        while (run !== 1'b1 && c < lim) begin
            @(posedge ref_clk_i);
            c++;
            e += int'(osc === 1'b1 && prev === 1'b0);
            prev = osc;
        end
    endtask
    // Cycles between two system clock ticks
    task automatic gap(output int p);
        int n;
        n = 0;
        p = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (tick !== 1'b1 && n < 3000);
        do begin
            @(posedge ref_clk_i);
            p++;
        end while (tick !== 1'b1 && p < 3000);
    endtask
    // System ticks within one period of the quarter clock
    task automatic qgap(output int p);
        int r;
        int n;
        logic prev;
        {r, n, p, prev} = {32'h0, 32'h0, 32'h0, 1'b1};
        while (r < 2 && n < 3000) begin
            @(posedge ref_clk_i);
            n++;
            p += int'(tick === 1'b1 && r == 1);
            r += int'(qout === 1'b1 && prev === 1'b0);
            prev = qout;
        end
    endtask
    // Counts and verdict
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (60000) @(posedge ref_clk_i);
        errors++;
        final_report();
    end
    // Test sequence
    initial begin
        int e;
        int c;
        int p;
        logic [31:0] d;
        repeat (4) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        wb(1'b0, ADDR_CTRL, 32'h0, d);
        chk(d[6:4], FREQ_RESET, "freq at reset");
        chk(d[0], ORIGIN_RESET, "origin at reset");
        wb(1'b1, ADDR_CFG, 32'h0000000F, d);
        wb(1'b1, 4'hC, 32'h000000FF, d);
        wb(1'b1, ADDR_TRIM, 32'h000000F5, d);
        chk(trim, 5'h15, "trim out");
        wb(1'b0, ADDR_CFG, 32'h0, d);
        chk(d, 32'h00000003, "config readback");
        wb(1'b0, 4'hC, 32'h0, d);
        chk(d, 32'h0, "unmapped read");
        $display("test registers done");
        // Pin use, start delay and quarter clock of the other modes
        for (int m = 3; m < 8; m++) begin
            boot(3'(m), 1'b0);
            e = 0;
            wait_run(20, e, c);
            chk(32'(c <= 3), 32'h1, "start delay");
            chk({in_io, out_io}, io_exp[m], "pin use");
            if (m == 3) begin
                gap(p);
                chk(32'(p), 32'd8, "driven clock");
            end
            if (m == 4 || m == 6) begin
                qgap(p);
                chk(32'(p), 32'd4, "quarter clock");
                chk(qoe_n, 1'b0, "quarter drive");
            end
        end
        $display("test modes done");
        // Crystal modes: gain, stall, stopped source and warm-up length
        for (int m = 0; m < 3; m++) begin
            boot(3'(m), m == 2);
            e = 0;
            wait_run(1500, e, c);
            chk(gain, GAIN_LOW + 2'(m), "amp gain");
            chk(run, 1'b0, "stall");
            osc_run <= 1'b0;
            repeat (300) @(posedge ref_clk_i);
            chk(run, 1'b0, "stopped source");
            osc_run <= 1'b1;
            wait_run(20000, e, c);
            chk(32'(e >= 1023 && e <= 1026), 32'h1, "warm-up length");
        end
        chk(fen, 1'b1, "two-speed enable");
        wb(1'b0, ADDR_CTRL, 32'h0, d);
        chk(d[3], 1'b1, "off-chip flag");
        wake <= 1'b1;
        @(posedge ref_clk_i);
        wake <= 1'b0;
        @(posedge ref_clk_i);
        chk(run, 1'b0, "wake stall");
        e = 0;
        wait_run(20000, e, c);
        chk(32'(e >= 1023 && e <= 1026), 32'h1, "wake warm-up");
        $display("test crystal done");
        // Software origin and every frequency code
        boot(MODE_DRIVEN, 1'b0);
        wait_run(20, e, c);
        chk(fen, 1'b0, "fast idle");
        for (int f = 7; f >= 0; f--) begin
            wb(1'b1, ADDR_CTRL, {25'h0, 3'(f), 4'h1}, d);
            gap(p);
            gap(p);
            chk(32'(p), (f == 0) ? 32'd20 : 32'(6 << (7 - f)), "rate");
            chk(fen, 1'(f != 0), "fast enable");
            wb(1'b0, ADDR_CTRL, 32'h0, d);
            chk(d[3:2], {1'b0, 1'(f != 0)}, "status flags");
        end
        chk(sen, 1'b1, "slow enable");
        $display("test rates done");
        final_report();
    end
endmodule // testbench
